// *** hdl/dsr_top.sv ***
`timescale 1ns/1ps
`include "dsr_defs.svh"
// How it works
// - Hard reset events make the next response register word $0004.
// - Soft reset $AA answers $1806; following $55 answers $0007.
// - Pulse stretch write answers $1X06 with echoed write and timer bits.
// - Command response has mode 01 and live deploy enable in D12.
// - D9 reports upper pair arming, D8 lower pair, stretch included.
// - Stretch started by deployment never sets arming flags.
// - Arming flags change only after the deglitch timer expires.
// - Each pair flag is the OR of its two channels.
// - Command D3..D0 echo the latest command write, no stretch status.
// - Diagnostic D13 battery short high node, D7 ground short low node.
// - Diagnostic mode 10; D11 live MOS diagnostic busy flag.
// - Diagnostic D10 one for high side MOS diagnostic.
// - Diagnostic D9 current on, D8 resistance current selected.
// - Diagnostic D6..D4 give the monitored channel.
// - Diagnostic D3 gives the squib current comparator.
// - Diagnostic D2..D0 give the diagnostic current channel.
// - Status mode 11, D13 zero, D3..D0 success or deploy-or-success.
// - Parity error or invalid word during deployment answers E000h.
// - Wrong clock count answers F000h.
// - Diagnostic channel 4..7 answers E800h.
// - Response D15:D14 encode register, command, diagnostic, status.
// - Host sends odd parity over all sixteen bits; device checks it.
// - Register D1 cleared by hard reset, set once read.
module dsr_top
  import dsr_pkg::*;
#(
  parameter int ARM_DGL_CYC = `DSR_ARM_DGL_CYC
) (
  input  wire logic       SYS_CLK_IN,
  input  wire logic       RESET_IN,
  input  wire logic       SPI_SCLK_IN,
  input  wire logic       SPI_CS_N_IN,
  input  wire logic       SPI_MOSI_IN,
  output logic            SPI_MISO_OUT,
  output logic            SPI_MISO_OE_OUT,
  input  wire logic       DEPLOY_ENABLE_PIN_IN,
  input  wire logic       EXTERNAL_RESET_N_IN,
  input  wire logic       LOSS_OF_GROUND_IN,
  input  wire logic       REFERENCE_RESISTOR_FAULT_IN,
  input  wire logic [3:0] ARM_CH_IN,
  input  wire logic [3:0] ARM_STRETCH_CH_IN,
  input  wire dsr_diag_s  DIAG_STAT_IN,
  input  wire logic [3:0] DEPLOY_ACTIVE_IN,
  input  wire logic [3:0] DEPLOY_SUCCESS_IN,
  output logic [3:0]      DEPLOY_CMD_OUT,
  output logic            DEPLOY_COND_OUT,
  output logic [1:0]      STRETCH_SEL_OUT,
  output logic [2:0]      MON_CH_OUT,
  output logic [2:0]      CUR_CH_OUT,
  output logic [3:0]      SUCCESS_CLEAR_OUT,
  output logic            SOFT_RESET_OUT
);

  // ========================================================
  // Pin synchronisers
  // Idle-high pins pass inverted so reset leaves no false edge
  localparam dsr_pins_s PIN_IDLE = '{cs_n: 1'b1, ext_rst_n: 1'b1,
                                     default: '0};
  dsr_pins_s raw, pin, pin_x;

  assign raw = '{sclk: SPI_SCLK_IN, cs_n: SPI_CS_N_IN,
                 mosi: SPI_MOSI_IN, deploy_enable_pin: DEPLOY_ENABLE_PIN_IN,
                 ext_rst_n: EXTERNAL_RESET_N_IN,
                 gnd_loss: LOSS_OF_GROUND_IN,
                 ref_fault: REFERENCE_RESISTOR_FAULT_IN,
                 diag: DIAG_STAT_IN, arm: ARM_CH_IN,
                 arm_str: ARM_STRETCH_CH_IN,
                 dep_act: DEPLOY_ACTIVE_IN,
                 dep_ok: DEPLOY_SUCCESS_IN};

  dsr_sync #(.WIDTH($bits(dsr_pins_s))) u_sync (
    .clk_in   (SYS_CLK_IN),
    .rst_in   (RESET_IN),
    .async_in (raw ^ PIN_IDLE),
    .sync_out (pin_x)
  );

  assign pin = pin_x ^ PIN_IDLE;

  // ========================================================
  // Arming flags
  // Only arming-initiated stretch enters; deploy stretch has no port
  logic [3:0] arm_any;
  logic [1:0] arm_pair;
  logic [1:0] arm_flag;

  assign arm_any  = pin.arm | pin.arm_str;
  assign arm_pair = {|arm_any[3:2], |arm_any[1:0]};

  dsr_deglitch #(.WIDTH(2), .LEN(ARM_DGL_CYC)) u_dgl (
    .clk_in   (SYS_CLK_IN),
    .rst_in   (RESET_IN),
    .raw_in   (arm_pair),
    .flag_out (arm_flag)
  );

  // ========================================================
  // Frame engine
  dsr_frm_e    frm_q, frm_d;
  logic        sclk_prev_q, cs_prev_q;
  logic [15:0] rx_q, rx_d, tx_q, tx_d;
  logic [4:0]  cnt_q, cnt_d;
  logic        sclk_rise, sclk_fall, cs_fall, cs_rise, hard_evt;
  logic        end_frame;

  assign sclk_rise = pin.sclk & ~sclk_prev_q;
  assign sclk_fall = ~pin.sclk & sclk_prev_q;
  assign cs_fall   = ~pin.cs_n & cs_prev_q;
  assign cs_rise   = pin.cs_n & ~cs_prev_q;
  assign hard_evt  = ~pin.ext_rst_n | pin.gnd_loss | pin.ref_fault;
  assign end_frame = cs_rise & (frm_q == FRM_BUSY);

  // ========================================================
  // Response state
  dsr_rsp_e    rsp_q, rsp_d;
  logic [15:0] flt_q, flt_d, rsp_word;
  logic        echo_rw_q, echo_rw_d, echo_sr_q, echo_sr_d;
  logic        sr_done_q, sr_done_d, sr_arm_q, sr_arm_d;
  logic        hard_ok_q, hard_ok_d, shipped_reg_q, shipped_reg_d;
  logic        cond_q, cond_d, msel_q, msel_d;
  logic [1:0]  str_q, str_d;
  logic [3:0]  cmd_q, cmd_d, dep_lat_q, dep_lat_d, clr_q, clr_d;
  logic [2:0]  mon_q, mon_d, cur_q, cur_d;
  logic        srst_q, srst_d;
  logic [3:0]  stat_bits;

  // Word decode of the finished frame
  logic [1:0]  mode;
  logic        bad_cnt, bad_par, bad_ch, bad_dep;

  assign mode    = rx_q[15:14];
  assign bad_cnt = cnt_q != 5'(`DSR_WORD_BITS);
  assign bad_par = ~^rx_q;
  assign bad_ch  = (mode == `DSR_MODE_DIAG)
                 & (rx_q[6] | rx_q[2]);
  assign bad_dep = (|pin.dep_act) & ((mode == `DSR_MODE_REG)
                 | (mode == `DSR_MODE_DIAG));

  assign stat_bits = msel_q ? (dep_lat_q | pin.dep_ok)
                            : pin.dep_ok;

  // Live bits are taken when the frame opens
  always_comb begin
    rsp_word = flt_q;
    unique case (rsp_q)
      RSP_REG:
        rsp_word = {3'b000, echo_rw_q, echo_sr_q,
                    cond_q & ~echo_sr_q, str_q & {2{~echo_sr_q}},
                    5'h00, 1'b1, hard_ok_q, sr_done_q};
      RSP_CMD:
        rsp_word = {`DSR_MODE_CMD, 1'b0, pin.deploy_enable_pin, 2'b00,
                    arm_flag, 4'h0, cmd_q};
      RSP_DIAG:
        rsp_word = {`DSR_MODE_DIAG, pin.diag.sb_hi, pin.deploy_enable_pin,
                    pin.diag.mos_busy, pin.diag.mos_hs,
                    pin.diag.cur_on, pin.diag.cur_src,
                    pin.diag.sg_lo, mon_q,
                    pin.diag.cur_cmp, cur_q};
      RSP_STAT:
        rsp_word = {`DSR_MODE_STAT, 1'b0, pin.deploy_enable_pin, 2'b00,
                    arm_flag, 4'h0, stat_bits};
      RSP_FAULT:
        rsp_word = flt_q;
    endcase
  end

  // ========================================================
  // Shift and frame sequencing
  always_comb begin
    frm_d = frm_q;
    rx_d  = rx_q;
    tx_d  = tx_q;
    cnt_d = cnt_q;
    shipped_reg_d = shipped_reg_q;
    if (cs_fall) begin
      frm_d = FRM_BUSY;
      tx_d  = rsp_word;
      cnt_d = 5'h00;
      shipped_reg_d = (rsp_q == RSP_REG);
    end else if (frm_q == FRM_BUSY) begin
      if (cs_rise) begin
        frm_d = FRM_IDLE;
      end else begin
        if (sclk_rise) begin
          rx_d = {rx_q[14:0], pin.mosi};
          if (cnt_q != `DSR_CNT_MAX) begin
            cnt_d = cnt_q + 5'h01;
          end
        end
        if (sclk_fall) begin
          tx_d = {tx_q[14:0], 1'b0};
        end
      end
    end
  end

  // ========================================================
  // Word evaluation at frame end
  always_comb begin
    rsp_d     = rsp_q;
    flt_d     = flt_q;
    echo_rw_d = echo_rw_q;
    echo_sr_d = echo_sr_q;
    sr_done_d = sr_done_q;
    sr_arm_d  = sr_arm_q;
    hard_ok_d = hard_ok_q;
    cond_d    = cond_q;
    str_d     = str_q;
    msel_d    = msel_q;
    cmd_d     = cmd_q;
    mon_d     = mon_q;
    cur_d     = cur_q;
    dep_lat_d = dep_lat_q;
    clr_d     = 4'h0;
    srst_d    = 1'b0;
    if (end_frame) begin
      dep_lat_d = pin.dep_act;
      if (shipped_reg_q) begin
        hard_ok_d = 1'b1;
      end
      if (bad_cnt | bad_par | bad_ch | bad_dep) begin
        rsp_d    = RSP_FAULT;
        sr_arm_d = 1'b0;
        if (bad_cnt) begin
          flt_d = `DSR_FLT_CLK;
        end else if (bad_par) begin
          flt_d = `DSR_FLT_PAR;
        end else if (bad_ch) begin
          flt_d = `DSR_FLT_CH;
        end else begin
          flt_d = `DSR_FLT_PAR;
        end
      end else begin
        unique case (mode)
          `DSR_MODE_REG: begin
            rsp_d     = RSP_REG;
            echo_rw_d = rx_q[`DSR_B_RW];
            echo_sr_d = rx_q[`DSR_B_SR];
            sr_done_d = 1'b0;
            sr_arm_d  = 1'b0;
            if (rx_q[`DSR_B_SR]) begin
              if (rx_q[7:0] == `DSR_SR_KEY1) begin
                sr_arm_d = 1'b1;
              end else if (sr_arm_q
                           && rx_q[7:0] == `DSR_SR_KEY2) begin
                echo_rw_d = 1'b0;
                echo_sr_d = 1'b0;
                sr_done_d = 1'b1;
                srst_d    = 1'b1;
                cmd_d     = 4'h0;
                mon_d     = 3'h0;
                cur_d     = 3'h0;
                msel_d    = 1'b0;
              end
            end else if (rx_q[`DSR_B_RW]) begin
              cond_d = rx_q[`DSR_B_COND];
              str_d  = rx_q[9:8];
            end
          end
          `DSR_MODE_CMD: begin
            rsp_d    = RSP_CMD;
            sr_arm_d = 1'b0;
            cmd_d    = rx_q[3:0];
          end
          `DSR_MODE_DIAG: begin
            rsp_d    = RSP_DIAG;
            sr_arm_d = 1'b0;
            mon_d    = rx_q[6:4];
            cur_d    = rx_q[2:0];
          end
          `DSR_MODE_STAT: begin
            rsp_d    = RSP_STAT;
            sr_arm_d = 1'b0;
            msel_d   = rx_q[`DSR_B_MSEL];
            clr_d    = rx_q[3:0];
          end
        endcase
      end
    end
    // Hard events override the response and settings the frame decided, not clr_d, srst_d or dep_lat_d
    if (hard_evt) begin
      rsp_d     = RSP_REG;
      echo_rw_d = 1'b0;
      echo_sr_d = 1'b0;
      sr_done_d = 1'b0;
      sr_arm_d  = 1'b0;
      hard_ok_d = 1'b0;
      cond_d    = 1'b0;
      str_d     = 2'h0;
      msel_d    = 1'b0;
      cmd_d     = 4'h0;
      mon_d     = 3'h0;
      cur_d     = 3'h0;
    end
  end

  // ========================================================
  // Registers
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      frm_q         <= FRM_IDLE;
      sclk_prev_q   <= 1'b0;
      cs_prev_q     <= 1'b1;
      rx_q          <= 16'h0000;
      tx_q          <= 16'h0000;
      cnt_q         <= 5'h00;
      shipped_reg_q <= 1'b0;
      rsp_q         <= RSP_REG;
      flt_q         <= 16'h0000;
      echo_rw_q     <= 1'b0;
      echo_sr_q     <= 1'b0;
      sr_done_q     <= 1'b0;
      sr_arm_q      <= 1'b0;
      hard_ok_q     <= 1'b0;
      cond_q        <= 1'b0;
      str_q         <= 2'h0;
      msel_q        <= 1'b0;
      cmd_q         <= 4'h0;
      mon_q         <= 3'h0;
      cur_q         <= 3'h0;
      dep_lat_q     <= 4'h0;
      clr_q         <= 4'h0;
      srst_q        <= 1'b0;
    end else begin
      frm_q         <= frm_d;
      sclk_prev_q   <= pin.sclk;
      cs_prev_q     <= pin.cs_n;
      rx_q          <= rx_d;
      tx_q          <= tx_d;
      cnt_q         <= cnt_d;
      shipped_reg_q <= shipped_reg_d;
      rsp_q         <= rsp_d;
      flt_q         <= flt_d;
      echo_rw_q     <= echo_rw_d;
      echo_sr_q     <= echo_sr_d;
      sr_done_q     <= sr_done_d;
      sr_arm_q      <= sr_arm_d;
      hard_ok_q     <= hard_ok_d;
      cond_q        <= cond_d;
      str_q         <= str_d;
      msel_q        <= msel_d;
      cmd_q         <= cmd_d;
      mon_q         <= mon_d;
      cur_q         <= cur_d;
      dep_lat_q     <= dep_lat_d;
      clr_q         <= clr_d;
      srst_q        <= srst_d;
    end
  end

  // ========================================================
  // Outputs
  assign SPI_MISO_OUT      = tx_q[15];
  assign SPI_MISO_OE_OUT   = (frm_q == FRM_BUSY);
  assign DEPLOY_CMD_OUT    = cmd_q;
  assign DEPLOY_COND_OUT   = cond_q;
  assign STRETCH_SEL_OUT   = str_q;
  assign MON_CH_OUT        = mon_q;
  assign CUR_CH_OUT        = cur_q;
  assign SUCCESS_CLEAR_OUT = clr_q;
  assign SOFT_RESET_OUT    = srst_q;

endmodule // dsr_top

// *** hdl/dsr_defs.svh ***
`ifndef DSR_DEFS_SVH
`define DSR_DEFS_SVH

// ==========================================================
// Timing
`define DSR_CLK_NS        100
`define DSR_ARM_DGL_NS    2000
`define DSR_ARM_DGL_CYC   ((`DSR_ARM_DGL_NS + `DSR_CLK_NS - 1) / `DSR_CLK_NS)

// ==========================================================
// Frame and field positions
`define DSR_WORD_BITS     16
`define DSR_CNT_MAX       5'h1F
`define DSR_B_RW          12
`define DSR_B_SR          11
`define DSR_B_COND        10
`define DSR_B_MSEL        8
`define DSR_MODE_REG      2'h0
`define DSR_MODE_CMD      2'h1
`define DSR_MODE_DIAG     2'h2
`define DSR_MODE_STAT     2'h3

// ==========================================================
// Soft reset keys and fault words
`define DSR_SR_KEY1       8'hAA
`define DSR_SR_KEY2       8'h55
`define DSR_FLT_PAR       16'hE000
`define DSR_FLT_CLK       16'hF000
`define DSR_FLT_CH        16'hE800

`endif

// *** hdl/dsr_pkg.sv ***
package dsr_pkg;

  typedef enum logic [2:0] {
    RSP_REG,
    RSP_CMD,
    RSP_DIAG,
    RSP_STAT,
    RSP_FAULT
  } dsr_rsp_e;

  typedef enum logic {
    FRM_IDLE,
    FRM_BUSY
  } dsr_frm_e;

  typedef struct packed {
    logic sb_hi;
    logic sg_lo;
    logic mos_busy;
    logic mos_hs;
    logic cur_on;
    logic cur_src;
    logic cur_cmp;
  } dsr_diag_s;

  typedef struct packed {
    logic       sclk;
    logic       cs_n;
    logic       mosi;
    logic       deploy_enable_pin;
    logic       ext_rst_n;
    logic       gnd_loss;
    logic       ref_fault;
    dsr_diag_s  diag;
    logic [3:0] arm;
    logic [3:0] arm_str;
    logic [3:0] dep_act;
    logic [3:0] dep_ok;
  } dsr_pins_s;

endpackage

// *** hdl/dsr_sync.sv ***
`timescale 1ns/1ps
module dsr_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_q, s2_q, s3_q, f_q, f_d;

  // Output moves only when the last two stages agree
  always_comb begin
    f_d = (s2_q & s3_q) | (f_q & (s2_q ^ s3_q));
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      f_q  <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q  <= f_d;
    end
  end

  assign sync_out = f_q;
endmodule // dsr_sync

// *** hdl/dsr_deglitch.sv ***
`timescale 1ns/1ps
module dsr_deglitch #(
  parameter int WIDTH = 2,
  parameter int LEN   = 20
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] raw_in,
  output logic      [WIDTH-1:0] flag_out
);
  localparam int CW = $clog2(LEN + 1);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic [CW-1:0] cnt_q, cnt_d;
      logic          flg_q, flg_d;

      // Flag follows the input only after it held for LEN cycles
      always_comb begin
        cnt_d = '0;
        flg_d = flg_q;
        if (raw_in[g] != flg_q) begin
          if (cnt_q == CW'(LEN - 1)) begin
            flg_d = raw_in[g];
          end else begin
            cnt_d = cnt_q + CW'(1);
          end
        end
      end

      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          cnt_q <= '0;
          flg_q <= 1'b0;
        end else begin
          cnt_q <= cnt_d;
          flg_q <= flg_d;
        end
      end

      assign flag_out[g] = flg_q;
    end
  endgenerate
endmodule // dsr_deglitch

// *** bench/dsr_resp_checker.sv ***
`timescale 1ns/1ps
module dsr_resp_checker #(
  parameter int ARM_DGL_CYC = 20
) (
  input wire logic       SYS_CLK_IN,
  input wire logic       RESET_IN,
  input wire logic       SPI_SCLK_IN,
  input wire logic       SPI_CS_N_IN,
  input wire logic       SPI_MISO_OUT,
  input wire logic       SPI_MISO_OE_OUT,
  input wire logic [3:0] DEPLOY_CMD_OUT,
  input wire logic       DEPLOY_COND_OUT,
  input wire logic [1:0] STRETCH_SEL_OUT,
  input wire logic [2:0] MON_CH_OUT,
  input wire logic [2:0] CUR_CH_OUT,
  input wire logic [3:0] SUCCESS_CLEAR_OUT,
  input wire logic       SOFT_RESET_OUT
);
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RESET_IN);
  // ==========================================================
  // Framing
  property p_oe_opens;
    $fell(SPI_CS_N_IN) |-> ##[2:6] SPI_MISO_OE_OUT;
  endproperty
  a_oe_opens: assert property (p_oe_opens) else $error("oe late");
  property p_oe_closes;
    SPI_CS_N_IN [*7] |-> !SPI_MISO_OE_OUT;
  endproperty
  a_oe_closes: assert property (p_oe_closes) else $error("oe stuck");
  property p_oe_frame;
    $rose(SPI_MISO_OE_OUT) |-> !SPI_CS_N_IN;
  endproperty
  a_oe_frame: assert property (p_oe_frame) else $error("oe no cs");
  // Bits may only move while the host holds its clock low
  property p_miso_edge;
    $changed(SPI_MISO_OUT) && SPI_MISO_OE_OUT |-> !SPI_SCLK_IN;
  endproperty
  a_miso_edge: assert property (p_miso_edge) else $error("miso skew");
  // ==========================================================
  // Word side effects
  property p_soft_once;
    SOFT_RESET_OUT |=> !SOFT_RESET_OUT;
  endproperty
  a_soft_once: assert property (p_soft_once) else $error("soft long");
  property p_soft_gap;
    SOFT_RESET_OUT |-> SPI_CS_N_IN && !SPI_MISO_OE_OUT;
  endproperty
  a_soft_gap: assert property (p_soft_gap) else $error("soft early");
  property p_clr_once;
    |SUCCESS_CLEAR_OUT |=> SUCCESS_CLEAR_OUT == 4'h0;
  endproperty
  a_clr_once: assert property (p_clr_once) else $error("clr long");
  property p_cfg_hold;
    !$stable({DEPLOY_CMD_OUT, DEPLOY_COND_OUT, STRETCH_SEL_OUT,
      MON_CH_OUT, CUR_CH_OUT}) |-> SPI_CS_N_IN && !SPI_MISO_OE_OUT;
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("cfg moved");
  property p_ch_valid;
    !MON_CH_OUT[2] && !CUR_CH_OUT[2];
  endproperty
  a_ch_valid: assert property (p_ch_valid) else $error("bad chan");
  c_soft: cover property (SOFT_RESET_OUT);
  c_clr: cover property (|SUCCESS_CLEAR_OUT);
  c_open: cover property ($rose(SPI_MISO_OE_OUT));
endmodule // dsr_resp_checker

bind dsr_top dsr_resp_checker #(.ARM_DGL_CYC(ARM_DGL_CYC)) u_chk (
  .SYS_CLK_IN(SYS_CLK_IN), .RESET_IN(RESET_IN),
  .SPI_SCLK_IN(SPI_SCLK_IN), .SPI_CS_N_IN(SPI_CS_N_IN),
  .SPI_MISO_OUT(SPI_MISO_OUT), .SPI_MISO_OE_OUT(SPI_MISO_OE_OUT),
  .DEPLOY_CMD_OUT(DEPLOY_CMD_OUT), .DEPLOY_COND_OUT(DEPLOY_COND_OUT),
  .STRETCH_SEL_OUT(STRETCH_SEL_OUT), .MON_CH_OUT(MON_CH_OUT),
  .CUR_CH_OUT(CUR_CH_OUT), .SUCCESS_CLEAR_OUT(SUCCESS_CLEAR_OUT),
  .SOFT_RESET_OUT(SOFT_RESET_OUT)
);

// *** bench/dsr_host_model.sv ***
`timescale 1ns/1ps
module dsr_host_model (
  input  wire logic clk_in,
  input  wire logic miso_in,
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      mosi_out
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #10;
  endtask
  // ==========================================================
  // Frame; half period of 6 clocks leaves margin over sync delay
  task automatic xfer(input logic [15:0] tx, input int nb,
                      output logic [15:0] rx);
    rx = 16'h0000;
    step(1);
    cs_n_out = 1'b0;
    for (int i = 0; i < nb; i++) begin
      mosi_out = tx[15 - (i % 16)];
      step(6);
      sclk_out = 1'b1;
      rx = {rx[14:0], miso_in};
      step(6);
      sclk_out = 1'b0;
    end
    step(6);
    cs_n_out = 1'b1;
    mosi_out = ~mosi_out;
    step(15);
  endtask
endmodule // dsr_host_model

// *** bench/dsr_top_test.sv ***
`timescale 1ns/1ps
module dsr_top_test
  import dsr_pkg::*;
;
  logic       clk, rst, sclk, cs_n, mosi, miso, dep, cond, oe, srst;
  logic [2:0] hev, mon, cur;
  logic [3:0] arm, act, suc, cmd, astr, clr;
  logic [3:0] clr_seen = 4'h0;
  int         n_srst = 0;
  int         n_oe = 0;
  logic [1:0] str;
  dsr_diag_s  diag;
  int         mismatches;
  int         n_tests;

  dsr_top #(.ARM_DGL_CYC(4)) dut (
    .SYS_CLK_IN(clk), .RESET_IN(rst), .SPI_SCLK_IN(sclk),
    .SPI_CS_N_IN(cs_n), .SPI_MOSI_IN(mosi), .SPI_MISO_OUT(miso),
    .SPI_MISO_OE_OUT(oe), .DEPLOY_ENABLE_PIN_IN(dep),
    .EXTERNAL_RESET_N_IN(~hev[0]), .LOSS_OF_GROUND_IN(hev[1]),
    .REFERENCE_RESISTOR_FAULT_IN(hev[2]), .ARM_CH_IN(arm),
    .ARM_STRETCH_CH_IN(astr), .DIAG_STAT_IN(diag),
    .DEPLOY_ACTIVE_IN(act), .DEPLOY_SUCCESS_IN(suc),
    .DEPLOY_CMD_OUT(cmd), .DEPLOY_COND_OUT(cond), .STRETCH_SEL_OUT(str),
    .MON_CH_OUT(mon), .CUR_CH_OUT(cur), .SUCCESS_CLEAR_OUT(clr),
    .SOFT_RESET_OUT(srst)
  );
  dsr_host_model host (
    .clk_in(clk), .miso_in(miso), .sclk_out(sclk), .cs_n_out(cs_n),
    .mosi_out(mosi)
  );
  always #50 clk = ~clk;
  // One-cycle pulses are caught here, checked later by the scenarios
  always @(posedge clk) begin
    if (srst) begin
      n_srst <= n_srst + 1;
    end
    if (|clr) begin
      clr_seen <= clr;
    end
  end
  always @(posedge sclk) begin
    if (oe) begin
      n_oe <= n_oe + 1;
    end
  end
  // ==========================================================
  // Helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [15:0] par(input logic [15:0] w);
    logic [15:0] r;
    r = w;
    r[13] = ~^{w[15:14], w[12:0]};
    return r;
  endfunction
  // Each frame returns the answer to the frame before it
  task automatic go(input string what, input logic [15:0] tx,
                    input logic [15:0] exp);
    logic [15:0] rx;
    host.xfer(tx, 16, rx);
    chk(what, exp, rx);
  endtask
  // ==========================================================
  // Scenarios, chained in order
  task automatic t_soft;
    go("first", par(16'h18AA), 16'h0004);
    chk("oe bits", 16'h0010, 16'(n_oe));
    chk("oe idle", 16'h0000, {15'h0000, oe});
    go("key one", par(16'h1855), 16'h1806);
    chk("soft pulse", 16'h0001, 16'(n_srst));
    go("key two", par(16'h1600), 16'h0007);
    chk("stretch cfg", 16'h0006, {13'h0000, cond, str});
    go("stretch", par(16'h400A), 16'h1606);
  endtask
  task automatic t_cmd;
    chk("cmd out", 16'h000A, {12'h000, cmd});
    go("cmd", par(16'h4005), 16'h520A);
    arm = 4'b0001;
    dep = 1'b0;
    tick(10);
    go("cmd", par(16'h8032), 16'h4105);
  endtask
  task automatic t_diag;
    chk("chan", 16'h0032, {9'h000, mon, 1'b0, cur});
    diag = 7'b1010101;
    tick(10);
    go("diag", par(16'h8021), 16'hAA3A);
    diag = 7'b0101010;
    dep = 1'b1;
    tick(10);
    go("diag", par(16'h8004), 16'h95A1);
    go("bad chan", par(16'h8070), 16'hE800);
    chk("chan kept", 16'h0021, {9'h000, mon, 1'b0, cur});
  endtask
  task automatic t_stat;
    suc  = 4'b0101;
    astr = 4'b0100;
    tick(10);
    go("bad chan", par(16'hC000), 16'hE800);
    act = 4'b0010;
    tick(10);
    go("status", par(16'hC101), 16'hD305);
    chk("clear", 16'h0001, {12'h000, clr_seen});
    go("status", par(16'h8021), 16'hD307);
    act = 4'b0000;
    tick(10);
    go("deploying", par(16'h4003) ^ 16'h2000, 16'hE000);
  endtask
  task automatic t_fault;
    logic [15:0] rx;
    chk("cmd kept", 16'h0005, {12'h000, cmd});
    go("parity", par(16'h4003), 16'hE000);
    host.xfer(par(16'h4003), 15, rx);
    go("count", par(16'h4003), 16'hF000);
    host.xfer(par(16'h4003) ^ 16'h2000, 17, rx);
    go("priority", par(16'h4003), 16'hF000);
    chk("cmd out", 16'h0003, {12'h000, cmd});
  endtask
  task automatic t_hard;
    for (int k = 0; k < 3; k++) begin
      hev = 3'b001 << k;
      tick(10);
      hev = 3'b000;
      tick(10);
      chk("cmd cleared", 16'h0000, {12'h000, cmd});
      go("hard event", par(16'h4003), 16'h0004);
    end
    // Second reset in mid-run, with a command word pending
    rst = 1'b1;
    tick(6);
    rst = 1'b0;
    tick(4);
    chk("cmd reset", 16'h0000, {12'h000, cmd});
    go("power on", par(16'h4003), 16'h0004);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    dep = 1'b1;
    hev = 3'b000;
    arm = 4'b0100;
    astr = 4'h0;
    diag = '0;
    act = 4'h0;
    suc = 4'h0;
    mismatches = 0;
    n_tests = 0;
    tick(6);
    rst = 1'b0;
    tick(4);
    t_soft;
    t_cmd;
    t_diag;
    t_stat;
    t_fault;
    t_hard;
    wrap_up;
  end
endmodule // dsr_top_test
